// [pkg/spe_pkg.sv]
package spe_pkg;
  // ==========================================================================
  // key and link constants
  // ==========================================================================
  localparam int          KEY_BITS       = 32;
  localparam logic [31:0] ENTRY_KEY      = 32'h5A3C_96E1; // arbitrary key value, shifted msb first
  localparam int          WORD_BITS      = 8;
  localparam int          CNT_W          = 6;
  localparam logic [5:0]  KEY_LAST       = 6'h1F;
  localparam logic [5:0]  WORD_LAST      = 6'h07;
  // host serial clock half period in system clocks (80 ns at 10 ns)
  localparam int          SCK_HALF_NS    = 80;
  localparam int          CLK_NS         = 10;
  localparam int          SCK_HALF_CYC   = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SCK_HALF_LAST  = 4'(SCK_HALF_CYC - 1);
  // host command codes on the user side
  localparam logic [1:0]  CMD_LV_ENTRY   = 2'h0;
  localparam logic [1:0]  CMD_HV_ENTRY   = 2'h1;
  localparam logic [1:0]  CMD_WRITE      = 2'h2;
  localparam logic [1:0]  CMD_READ       = 2'h3;
  // buffer depth
  localparam int          BUF_DEPTH      = 2;
endpackage

// [pkg/spe_link_if.sv]
`timescale 1ns/100ps
interface spe_link_if;
  logic prog_serial_clock;        // driven by the programmer
  logic prog_serial_data_host_o;  // host drive value
  logic prog_serial_data_host_oe; // host drives data
  logic prog_serial_data_dev_o;   // device drive value
  logic prog_serial_data_dev_oe;  // device drives data
  logic master_clear_pin;         // low holds the mode
  logic high_entry_voltage_level; // master clear raised to programming voltage
  logic prog_serial_data;         // resolved wire level
  // resolve the bidirectional data wire, pulled low when idle
  assign prog_serial_data = prog_serial_data_host_oe ? prog_serial_data_host_o :
                            prog_serial_data_dev_oe  ? prog_serial_data_dev_o  : 1'b0;
  modport dev (
    input  prog_serial_clock,
    input  prog_serial_data,
    input  master_clear_pin,
    input  high_entry_voltage_level,
    output prog_serial_data_dev_o,
    output prog_serial_data_dev_oe
  );
  modport host (
    output prog_serial_clock,
    input  prog_serial_data,
    output master_clear_pin,
    output high_entry_voltage_level,
    output prog_serial_data_host_o,
    output prog_serial_data_host_oe
  );
endinterface

// [rtl/spe_device.sv]
// Behaviour
// RULE1: host holds clock, data low before high voltage
// RULE2: key entry only when low-voltage enable is 1
// RULE3: host lowers master clear, shifts 32-bit key
// RULE4: mode held only while master clear low; high-voltage sessions held by the raised voltage instead
// RULE5: enable forces master clear reset function on
// RULE6: enable clears only in high-voltage sessions
// RULE7: clock input; data pin bidirectional
// RULE8: memory, ids, config words written over link
// RULE9: one key bit per clock; all must match
`timescale 1ns/100ps
module spe_device (
  // system
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // link
  spe_link_if.dev         link,
  // configuration
  input  wire logic       low_voltage_entry_enable_i,
  input  wire logic       master_clear_pin_reset_cfg_i,
  // received words towards memory
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output logic [7:0]      rx_data_o,
  // read-back words from memory
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  // status
  output logic            prog_mode_o,
  output logic            hv_session_o,
  output logic            master_clear_pin_reset_en_o,
  output logic            lve_clear_allow_o
);
  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  typedef enum logic [2:0] {
    SPE_IDLE = 3'b001,
    SPE_KEY  = 3'b010,
    SPE_PROG = 3'b100
  } spe_dstate_e;

  logic [2:0] sck_q, sck_d, dat_q, dat_d, master_clear_pin_q, master_clear_pin_d, hv_q, hv_d;
  // two stages plus an edge history stage on the clock
  always_comb begin
    sck_d  = {sck_q[1:0], link.prog_serial_clock};
    dat_d  = {dat_q[1:0], link.prog_serial_data};
    master_clear_pin_d = {master_clear_pin_q[1:0], link.master_clear_pin};
    hv_d   = {hv_q[1:0], link.high_entry_voltage_level};
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q  <= 3'h0;
      dat_q  <= 3'h0;
      master_clear_pin_q <= 3'h7;
      hv_q   <= 3'h0;
    end else begin
      sck_q  <= sck_d;
      dat_q  <= dat_d;
      master_clear_pin_q <= master_clear_pin_d;
      hv_q   <= hv_d;
    end
  end
  logic sck_rise, sck_fall, dat_s, dat_f, master_clear_pin_s, hv_s;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign dat_s    = dat_q[1];
  // host moves data on the edge its clock falls, so take the bit that stood just before
  assign dat_f    = dat_q[2];
  assign master_clear_pin_s   = master_clear_pin_q[1];
  assign hv_s     = hv_q[1];

  // ==========================================================================
  // entry and session state
  // ==========================================================================
  spe_dstate_e st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic        hv_ses_q, hv_ses_d;
  logic        dir_rd_q, dir_rd_d;
  logic [7:0]  txsh_q, txsh_d;
  logic        drv_q, drv_d, dout_q, dout_d;
  logic [7:0]  buf_q [2];
  logic [7:0]  buf_d [2];
  logic [1:0]  cnt_buf_q, cnt_buf_d;
  logic        wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic        txrdy_q, txrdy_d;

  // next state of entry, key shift, word shift and the two-entry buffer
  always_comb begin
    logic push;
    logic pop;
    push      = 1'b0;
    pop       = rx_valid_o & rx_ready_i;
    st_d      = st_q;
    cnt_d     = cnt_q;
    sh_d      = sh_q;
    hv_ses_d  = hv_ses_q;
    dir_rd_d  = dir_rd_q;
    txsh_d    = txsh_q;
    drv_d     = drv_q;
    dout_d    = dout_q;
    buf_d     = buf_q;
    wr_ptr_d  = wr_ptr_q;
    rd_ptr_d  = rd_ptr_q;
    txrdy_d   = 1'b0;
    unique case (st_q)
      SPE_IDLE: begin
        cnt_d = 6'h0;
        if (hv_s && !sck_q[1] && !dat_s) begin // RULE1
          st_d     = SPE_PROG;
          hv_ses_d = 1'b1;
        end else if (!master_clear_pin_s && low_voltage_entry_enable_i) begin // RULE2 RULE3
          st_d = SPE_KEY;
        end
      end
      SPE_KEY: begin
        if (master_clear_pin_s || !low_voltage_entry_enable_i) begin
          st_d = SPE_IDLE;
        end else if (sck_fall) begin // RULE9
          sh_d  = {sh_q[30:0], dat_f};
          cnt_d = cnt_q + 6'h1;
          if (cnt_q == spe_pkg::KEY_LAST) begin
            cnt_d    = 6'h0;
            hv_ses_d = 1'b0;
            st_d     = ({sh_q[30:0], dat_f} == spe_pkg::ENTRY_KEY) ? SPE_PROG : SPE_IDLE; // RULE9
          end
        end
      end
      SPE_PROG: begin
        // first bit of each word picks direction: 1 means read-back
        if ((hv_ses_q && !hv_s) || (!hv_ses_q && master_clear_pin_s)) begin // RULE4
          st_d     = SPE_IDLE;
          hv_ses_d = 1'b0;
          drv_d    = 1'b0;
          cnt_d    = 6'h0;
        end else if (cnt_q == 6'h0 && sck_fall) begin
          dir_rd_d = dat_f;
          cnt_d    = 6'h1;
          if (dat_f && tx_valid_i) begin
            txsh_d  = tx_data_i;
            txrdy_d = 1'b1;
          end else if (dat_f) begin
            txsh_d = 8'h00;
          end
        end else if (dir_rd_q && cnt_q != 6'h0 && sck_rise) begin // RULE7
          drv_d  = 1'b1;
          dout_d = txsh_q[7];
          txsh_d = {txsh_q[6:0], 1'b0};
        end else if (cnt_q != 6'h0 && sck_fall) begin // RULE8
          sh_d  = {sh_q[30:0], dat_f};
          cnt_d = cnt_q + 6'h1;
          if (cnt_q == spe_pkg::WORD_LAST + 6'h1) begin
            cnt_d = 6'h0;
            drv_d = 1'b0;
            push  = !dir_rd_q && (cnt_buf_q != 2'(spe_pkg::BUF_DEPTH));
          end
        end
      end
      default: st_d = SPE_IDLE;
    endcase
    // buffer towards memory; a full buffer drops no stored word
    if (push) begin
      buf_d[wr_ptr_q] = {sh_q[6:0], dat_f};
      wr_ptr_d        = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    cnt_buf_d = cnt_buf_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q      <= SPE_IDLE;
      cnt_q     <= 6'h0;
      sh_q      <= 32'h0;
      hv_ses_q  <= 1'b0;
      dir_rd_q  <= 1'b0;
      txsh_q    <= 8'h00;
      drv_q     <= 1'b0;
      dout_q    <= 1'b0;
      buf_q[0]  <= 8'h00;
      buf_q[1]  <= 8'h00;
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      cnt_buf_q <= 2'h0;
      txrdy_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      hv_ses_q  <= hv_ses_d;
      dir_rd_q  <= dir_rd_d;
      txsh_q    <= txsh_d;
      drv_q     <= drv_d;
      dout_q    <= dout_d;
      buf_q     <= buf_d;
      wr_ptr_q  <= wr_ptr_d;
      rd_ptr_q  <= rd_ptr_d;
      cnt_buf_q <= cnt_buf_d;
      txrdy_q   <= txrdy_d;
    end
  end

  // ==========================================================================
  // status outputs, all registered
  // ==========================================================================
  logic prog_q, hvo_q, mre_q, lca_q, rxv_q;
  logic [7:0] rxd_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_q <= 1'b0;
      hvo_q  <= 1'b0;
      mre_q  <= 1'b1;
      lca_q  <= 1'b0;
      rxv_q  <= 1'b0;
      rxd_q  <= 8'h00;
    end else begin
      prog_q <= (st_d == SPE_PROG);
      hvo_q  <= hv_ses_d;
      mre_q  <= master_clear_pin_reset_cfg_i | low_voltage_entry_enable_i; // RULE5
      lca_q  <= (st_d == SPE_PROG) & hv_ses_d; // RULE6
      rxv_q  <= (cnt_buf_d != 2'h0) & ~(rxv_q & rx_ready_i & cnt_buf_q == 2'h1 & cnt_buf_d == 2'h0);
      rxd_q  <= buf_d[rd_ptr_d];
    end
  end
  assign prog_mode_o                  = prog_q;
  assign hv_session_o                 = hvo_q;
  assign master_clear_pin_reset_en_o              = mre_q;
  assign lve_clear_allow_o            = lca_q;
  assign rx_valid_o                   = rxv_q;
  assign rx_data_o                    = rxd_q;
  assign tx_ready_o                   = txrdy_q;
  assign link.prog_serial_data_dev_o  = dout_q;
  assign link.prog_serial_data_dev_oe = drv_q; // RULE7
endmodule // spe_device

// [rtl/spe_host.sv]
`timescale 1ns/100ps
module spe_host (
  // system
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // link
  spe_link_if.host        link,
  // command side
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic [1:0] cmd_op_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       end_session_i,
  // read answer
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o,
  output logic            busy_o
);
  // ==========================================================================
  // host sequencer
  // ==========================================================================
  typedef enum logic [3:0] {
    SPH_IDLE  = 4'b0001,
    SPH_SETUP = 4'b0010,
    SPH_SHIFT = 4'b0100,
    SPH_HOLD  = 4'b1000
  } spe_hstate_e;

  spe_hstate_e st_q, st_d;
  logic [3:0]  div_q, div_d;
  logic [5:0]  bit_q, bit_d, last_q, last_d;
  logic [32:0] sh_q, sh_d;
  logic        sck_q, sck_d, master_clear_pin_q, master_clear_pin_d, hv_q, hv_d, oe_q, oe_d, rd_q, rd_d;
  logic        rdv_q, rdv_d, rdy_q, rdy_d;
  logic [7:0]  rdd_q, rdd_d;
  logic [1:0]  din_q, din_d;
  logic        busy_q;

  // data pin passes two flops before use
  always_comb din_d = {din_q[0], link.prog_serial_data};

  always_comb begin
    st_d   = st_q;
    div_d  = div_q + 4'h1;
    bit_d  = bit_q;
    last_d = last_q;
    sh_d   = sh_q;
    sck_d  = sck_q;
    master_clear_pin_d = master_clear_pin_q;
    hv_d   = hv_q;
    oe_d   = oe_q;
    rd_d   = rd_q;
    rdv_d  = 1'b0;
    rdd_d  = rdd_q;
    rdy_d  = 1'b0;
    unique case (st_q)
      SPH_IDLE: begin
        sck_d = 1'b0;
        oe_d  = 1'b1;
        sh_d  = 33'h0;
        if (cmd_valid_i && !rdy_q) begin
          rdy_d = 1'b1;
          div_d = 4'h0;
          unique case (cmd_op_i)
            spe_pkg::CMD_HV_ENTRY: begin
              hv_d = 1'b1; // RULE1
              st_d = SPH_HOLD;
            end
            spe_pkg::CMD_LV_ENTRY: begin
              master_clear_pin_d = 1'b0; // RULE3
              sh_d   = {spe_pkg::ENTRY_KEY, 1'b0};
              last_d = spe_pkg::KEY_LAST;
              rd_d   = 1'b0;
              st_d   = SPH_SETUP;
            end
            default: begin
              sh_d   = {cmd_op_i == spe_pkg::CMD_READ, cmd_data_i, 24'h0};
              last_d = spe_pkg::WORD_LAST + 6'h1;
              rd_d   = (cmd_op_i == spe_pkg::CMD_READ);
              st_d   = SPH_SETUP;
            end
          endcase
        end else if (end_session_i) begin
          master_clear_pin_d = 1'b1; // RULE4
          hv_d   = 1'b0;
        end
      end
      SPH_SETUP: begin
        bit_d = 6'h0;
        if (div_q == spe_pkg::SCK_HALF_LAST) begin
          div_d = 4'h0;
          st_d  = SPH_SHIFT;
        end
      end
      SPH_SHIFT: begin
        if (div_q == spe_pkg::SCK_HALF_LAST) begin
          div_d = 4'h0;
          sck_d = ~sck_q;
          if (!sck_q) begin
            oe_d = !(rd_q && bit_q != 6'h0); // RULE7
          end else begin
            sh_d  = {sh_q[31:0], 1'b0};
            bit_d = bit_q + 6'h1;
            if (rd_q && bit_q != 6'h0) begin
              rdd_d = {rdd_q[6:0], din_q[1]};
            end
            if (bit_q == last_q) begin
              rdv_d = rd_q;
              // after a read keep the wire released a half period so the device lets go first
              oe_d  = !rd_q; // RULE7
              st_d  = rd_q ? SPH_HOLD : SPH_IDLE;
            end
          end
        end
      end
      SPH_HOLD: begin
        if (div_q == spe_pkg::SCK_HALF_LAST) begin
          st_d = SPH_IDLE;
        end
      end
      default: st_d = SPH_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q   <= SPH_IDLE;
      div_q  <= 4'h0;
      bit_q  <= 6'h0;
      last_q <= 6'h0;
      sh_q   <= 33'h0;
      sck_q  <= 1'b0;
      master_clear_pin_q <= 1'b1;
      hv_q   <= 1'b0;
      oe_q   <= 1'b1;
      rd_q   <= 1'b0;
      rdv_q  <= 1'b0;
      rdd_q  <= 8'h00;
      rdy_q  <= 1'b0;
      din_q  <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      bit_q  <= bit_d;
      last_q <= last_d;
      sh_q   <= sh_d;
      sck_q  <= sck_d;
      master_clear_pin_q <= master_clear_pin_d;
      hv_q   <= hv_d;
      oe_q   <= oe_d;
      rd_q   <= rd_d;
      rdv_q  <= rdv_d;
      rdd_q  <= rdd_d;
      rdy_q  <= rdy_d;
      din_q  <= din_d;
      busy_q <= (st_d != SPH_IDLE);
    end
  end

  assign link.prog_serial_clock        = sck_q;
  assign link.master_clear_pin         = master_clear_pin_q;
  assign link.high_entry_voltage_level = hv_q;
  assign link.prog_serial_data_host_o  = sh_q[32];
  assign link.prog_serial_data_host_oe = oe_q;
  assign cmd_ready_o                   = rdy_q;
  assign rd_valid_o                    = rdv_q;
  assign rd_data_o                     = rdd_q;
  assign busy_o                        = busy_q;
endmodule // spe_host

// [bench/spe_link_asserts.sv]
`timescale 1ns/100ps
// ==========================================================================
// link wire checker
// ==========================================================================
module spe_link_asserts (
  // system
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // link wires
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data,
  input wire logic prog_serial_data_host_oe,
  input wire logic prog_serial_data_dev_oe,
  input wire logic master_clear_pin,
  input wire logic high_entry_voltage_level
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // host pins sit in their idle levels when reset lets go
  a_reset_pin_state: assert property ($rose(rst_b_i) |-> master_clear_pin && !prog_serial_clock
    && !high_entry_voltage_level) else $error("host pins not idle after reset");
  // clock and data stay low for four cycles after the raised voltage appears
  a_hv_entry_low: assert property ($rose(high_entry_voltage_level) |->
    (!prog_serial_clock && !prog_serial_data)[*4]) else $error("clock or data high at high-voltage entry");
  // never two drivers on the data wire
  a_no_contention: assert property (!(prog_serial_data_host_oe && prog_serial_data_dev_oe))
    else $error("both ends drive the data wire");
  // each clock phase stands a full half period
  a_clk_high_width: assert property ($rose(prog_serial_clock) |-> prog_serial_clock[*8])
    else $error("serial clock high phase too short");
  a_clk_low_width: assert property ($fell(prog_serial_clock) |-> !prog_serial_clock[*8])
    else $error("serial clock low phase too short");
  // clock stands still outside any session
  a_clk_idle_outside: assert property (master_clear_pin && !high_entry_voltage_level |-> !prog_serial_clock)
    else $error("serial clock moves outside a session");
  // setup gap after master clear falls, before the key
  a_key_setup_gap: assert property ($fell(master_clear_pin) && !high_entry_voltage_level |->
    !prog_serial_clock[*8]) else $error("key clocked too soon after master clear low");
  // device lets go of the data wire once master clear is released
  a_dev_release: assert property ($rose(master_clear_pin) |-> ##[0:6] !prog_serial_data_dev_oe)
    else $error("device still drives data after session end");

  // main scenarios
  c_hv_entry: cover property ($rose(high_entry_voltage_level));
  c_lv_entry: cover property ($fell(master_clear_pin));
  c_read_back: cover property ($rose(prog_serial_data_dev_oe));
endmodule // spe_link_asserts

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic       mclk_i      = 1'b0;
  logic       rst_b_i     = 1'b0;
  logic       lve         = 1'b1;
  logic       master_clear_pin_cfg    = 1'b0;
  logic       rx_ready    = 1'b0;
  logic       tx_valid    = 1'b0;
  logic [7:0] tx_data     = 8'h00;
  logic       cmd_valid   = 1'b0;
  logic [1:0] cmd_op      = 2'h0;
  logic [7:0] cmd_data    = 8'h00;
  logic       end_session = 1'b0;
  logic       rx_valid, tx_ready, prog_mode, hv_session, master_clear_pin_en, clear_allow;
  logic       cmd_ready, rd_valid, busy;
  logic [7:0] rx_data, rd_data, got_rd, status;
  logic       saw_txr     = 1'b0;
  int         n_mismatch  = 0;
  int         checks_done = 0;
  // rows: enable bit, other reset config, expected status
  logic [9:0] rows [4]    = '{10'h000, 10'h102, 10'h202, 10'h302};
  logic [7:0] wr [3]      = '{8'hA5, 8'h3C, 8'h0F};

  assign status = {4'h0, prog_mode, hv_session, master_clear_pin_en, clear_allow};
  // clock
  always #5 mclk_i = ~mclk_i;

  // ==========================================================================
  // design, link and checker
  // ==========================================================================
  spe_link_if spe_link_if_inst ();
  spe_device spe_device_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(spe_link_if_inst.dev),
    .low_voltage_entry_enable_i(lve), .master_clear_pin_reset_cfg_i(master_clear_pin_cfg),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
    .prog_mode_o(prog_mode), .hv_session_o(hv_session), .master_clear_pin_reset_en_o(master_clear_pin_en),
    .lve_clear_allow_o(clear_allow));
  spe_host spe_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(spe_link_if_inst.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_data_i(cmd_data),
    .end_session_i(end_session), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .busy_o(busy));
  spe_link_asserts spe_link_asserts_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .prog_serial_clock(spe_link_if_inst.prog_serial_clock),
    .prog_serial_data(spe_link_if_inst.prog_serial_data),
    .prog_serial_data_host_oe(spe_link_if_inst.prog_serial_data_host_oe),
    .prog_serial_data_dev_oe(spe_link_if_inst.prog_serial_data_dev_oe),
    .master_clear_pin(spe_link_if_inst.master_clear_pin),
    .high_entry_voltage_level(spe_link_if_inst.high_entry_voltage_level));

  // ==========================================================================
  // tasks
  // ==========================================================================
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one host command, held until taken, then wait for the host to settle
  task automatic cmd(input logic [1:0] op, input logic [7:0] data);
    int i;
    int idle;
    idle = 0;
    saw_txr = 1'b0;
    @(negedge mclk_i);
    cmd_op = op;
    cmd_data = data;
    cmd_valid = 1'b1;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge mclk_i);
    if (cmd_ready !== 1'b1) n_mismatch++;
    cmd_valid = 1'b0;
    for (i = 0; i < 3000 && idle < 12; i++) begin
      @(negedge mclk_i);
      if (rd_valid === 1'b1) got_rd = rd_data;
      if (tx_ready === 1'b1) saw_txr = 1'b1;
      idle = (busy === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 12) n_mismatch++;
  endtask

  // accept one received word from the buffer
  task automatic take(input logic [7:0] exp);
    int i;
    for (i = 0; i < 50 && rx_valid !== 1'b1; i++) @(negedge mclk_i);
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(negedge mclk_i);
    rx_ready = 1'b0;
  endtask

  // release the pins and let the device drop out of the mode
  task automatic end_sess();
    end_session = 1'b1;
    repeat (16) @(negedge mclk_i);
    end_session = 1'b0;
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  // watchdog
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk(status, 8'h02);
    chk({6'h00, spe_link_if_inst.master_clear_pin, spe_link_if_inst.prog_serial_clock}, 8'h02);
    foreach (rows[k]) begin
      {lve, master_clear_pin_cfg} = rows[k][9:8];
      repeat (3) @(negedge mclk_i);
      chk(status, rows[k][7:0]);
    end
    // key entry refused while the enable bit is clear
    {lve, master_clear_pin_cfg} = 2'h0;
    cmd(spe_pkg::CMD_LV_ENTRY, 8'h00);
    chk(status, 8'h00);
    end_sess();
    // key entry, then fill the buffer while the receiver stalls
    lve = 1'b1;
    cmd(spe_pkg::CMD_LV_ENTRY, 8'h00);
    chk(status, 8'h0A);
    foreach (wr[k]) cmd(spe_pkg::CMD_WRITE, wr[k]);
    take(wr[0]);
    take(wr[1]);
    repeat (4) @(negedge mclk_i);
    chk({7'h00, rx_valid}, 8'h00);
    // read-back with and without a word on offer
    tx_data = 8'hC3;
    tx_valid = 1'b1;
    got_rd = 8'h55;
    cmd(spe_pkg::CMD_READ, 8'h00);
    chk(got_rd, 8'hC3);
    chk({7'h00, saw_txr}, 8'h01);
    tx_valid = 1'b0;
    cmd(spe_pkg::CMD_READ, 8'h00);
    chk(got_rd, 8'h00);
    chk({7'h00, saw_txr}, 8'h00);
    end_sess();
    chk(status, 8'h02);
    // high-voltage session, a write, then reset in mid-session
    cmd(spe_pkg::CMD_HV_ENTRY, 8'h00);
    chk(status, 8'h0F);
    cmd(spe_pkg::CMD_WRITE, 8'h81);
    take(8'h81);
    rst_b_i = 1'b0;
    @(negedge mclk_i);
    chk(status, 8'h02);
    chk({7'h00, spe_link_if_inst.high_entry_voltage_level}, 8'h00);
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(status, 8'h02);
    results();
  end
endmodule // tb
